// >>> verilog/ccpu_consts.svh
/*
  Register offsets, field positions, mode codes and timing counts for one
  capture/compare/PWM unit. Assumes inclusion by bare name from the unit files.
*/
`ifndef CCPU_CONSTS_SVH
`define CCPU_CONSTS_SVH

`define CCPU_ADDR_W 3
`define CCPU_OFS_CONTROL 3'h0
`define CCPU_OFS_DATA_LOW 3'h1
`define CCPU_OFS_DATA_HIGH 3'h2
`define CCPU_OFS_TSEL_ONE 3'h3
`define CCPU_OFS_TSEL_TWO 3'h4

`define CCPU_CONTROL_RST 8'h00
`define CCPU_TSEL_RST 8'h00
`define CCPU_TSEL_ONE_MASK 8'hD7
`define CCPU_TSEL_TWO_MASK 8'h17
`define CCPU_TSEL_TWO_SMALL_MASK 8'h03

`define CCPU_MODE_LSB 0
`define CCPU_DUTY_LSB 4
`define CCPU_OCFG_LSB 6

`define CCPU_MODE_OFF 4'h0
`define CCPU_MODE_TOGGLE 4'h2
`define CCPU_MODE_CAP_FALL 4'h4
`define CCPU_MODE_CAP_RISE 4'h5
`define CCPU_MODE_CAP_4TH 4'h6
`define CCPU_MODE_CAP_16TH 4'h7
`define CCPU_MODE_SET_HIGH 4'h8
`define CCPU_MODE_SET_LOW 4'h9
`define CCPU_MODE_SOFT_INT 4'hA
`define CCPU_MODE_TMR_RESET 4'hB

`define CCPU_OCFG_SINGLE 2'h0
`define CCPU_OCFG_FWD 2'h1
`define CCPU_OCFG_HALF 2'h2
`define CCPU_OCFG_REV 2'h3

`define CCPU_DEAD_NS 40
`define CCPU_CLK_MHZ 50
`define CCPU_DEAD_CYC ((`CCPU_DEAD_NS * `CCPU_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/ccpu_pkg.sv
/*
  Types shared by the unit files.
  Assumes the constants header sits beside it.
*/
package ccpu_pkg;

  typedef struct packed {
    logic [3:0][15:0] cc_cnt;
    logic [3:0][9:0] pwm_cnt;
    logic [3:0] pwm_wrap;
  } ccpu_timers_t;

  typedef enum logic [1:0] {
    OP_OFF,
    OP_CAPTURE,
    OP_COMPARE,
    OP_PWM
  } ccpu_op_t;

endpackage

// >>> verilog/ccpu_cap_edge.sv
/*
  Capture edge qualifier with prescaler.
  Assumes the pin is synchronous to the clock.
*/
`timescale 1ns/10ps
module ccpu_cap_edge (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic [1:0] i_sel,
  input wire logic i_pin,
  output logic o_event
);
  logic pin_q;
  logic [3:0] cnt_q;
  logic rise;
  logic fall;

  assign rise = i_pin & ~pin_q;
  assign fall = ~i_pin & pin_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_q <= 1'b0;
    end else if (i_ce) begin
      pin_q <= i_pin;
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || (i_ce && i_clear)) begin
      cnt_q <= 4'h0;
    end else if (i_ce && rise) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_comb begin
    case (i_sel)
      2'h0: o_event = fall;
      2'h1: o_event = rise;
      2'h2: o_event = rise && (cnt_q[1:0] == 2'h3);
      2'h3: o_event = rise && (cnt_q == 4'hF);
      default: o_event = 1'b0;
    endcase
  end
endmodule

// >>> verilog/ccpu_unit.sv
/*
  One capture/compare/PWM unit with the shared timer pick registers.
  Assumes timers, pin muxing and the interrupt flag register live outside;
  released pins (oe low) fall back to their port logic.
*/
`timescale 1ns/10ps
`include "ccpu_consts.svh"
module ccpu_unit #(
  parameter int UNIT_NUM = 4,
  parameter bit SMALL_MEM = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [`CCPU_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire ccpu_pkg::ccpu_timers_t i_timers,
  input wire logic i_cap_pin,
  input wire logic [3:0] i_steer,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  output logic o_flag_set,
  output logic o_tmr_reset,
  output logic [1:0] o_cc_sel,
  output logic [1:0] o_pwm_sel
);
  import ccpu_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] control_q;
  logic [7:0] tsel_one_q;
  logic [7:0] tsel_two_q;
  logic [7:0] data_low_q;
  logic [7:0] data_high_q;
  logic [1:0] duty_lsb_q;
  logic [7:0] tsel_two_mask;
  logic [3:0] mode;
  logic [1:0] ocfg;
  logic [3:0] new_mode;
  logic wr_ctrl;
  logic mode_off;
  ccpu_op_t op;

  assign tsel_two_mask = SMALL_MEM ? `CCPU_TSEL_TWO_SMALL_MASK : `CCPU_TSEL_TWO_MASK;
  assign mode = control_q[`CCPU_MODE_LSB +: 4];
  assign ocfg = control_q[`CCPU_OCFG_LSB +: 2];
  assign new_mode = i_wdata[`CCPU_MODE_LSB +: 4];
  assign wr_ctrl = i_wr && (i_addr == `CCPU_OFS_CONTROL);
  assign mode_off = (mode == `CCPU_MODE_OFF);

  always_comb begin
    case (mode[3:2])
      2'h1: op = OP_CAPTURE;
      2'h3: op = OP_PWM;
      default: op = mode_off ? OP_OFF : OP_COMPARE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      control_q <= `CCPU_CONTROL_RST;
    end else if (i_ce && wr_ctrl) begin
      control_q <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tsel_one_q <= `CCPU_TSEL_RST;
      tsel_two_q <= `CCPU_TSEL_RST;
    end else if (i_ce && i_wr) begin
      if (i_addr == `CCPU_OFS_TSEL_ONE) begin
        tsel_one_q <= i_wdata & `CCPU_TSEL_ONE_MASK;
      end
      if (i_addr == `CCPU_OFS_TSEL_TWO) begin
        tsel_two_q <= i_wdata & tsel_two_mask;
      end
    end
  end

  // ---------------------------------------------------------------
  // timer pick decode
  // ---------------------------------------------------------------
  // index n selects 16-bit timer 2n+1 and pwm timer 2n+2
  logic [1:0] cc_sel;
  logic [1:0] pwm_sel;

  always_comb begin
    cc_sel = 2'h0;
    pwm_sel = 2'h0;
    case (UNIT_NUM)
      4: begin
        case (tsel_one_q[1:0])
          2'h1: begin cc_sel = 2'h1; pwm_sel = 2'h1; end
          2'h2: begin cc_sel = 2'h1; pwm_sel = 2'h2; end
          default: begin cc_sel = 2'h0; pwm_sel = 2'h0; end
        endcase
      end
      5: begin
        if (tsel_one_q[2]) begin
          cc_sel = 2'h2;
          pwm_sel = 2'h1;
        end
      end
      6: begin
        if (tsel_one_q[4]) begin
          cc_sel = 2'h2;
        end
      end
      7: begin
        cc_sel = (tsel_one_q[7:6] == 2'h0) ? 2'h0 : 2'h2;
        pwm_sel = tsel_one_q[7:6];
      end
      8: begin
        if (tsel_two_q[1:0] == 2'h1 || tsel_two_q[1:0] == 2'h2) begin
          cc_sel = SMALL_MEM ? 2'h0 : 2'h3;
          pwm_sel = tsel_two_q[1:0];
        end
      end
      9: begin
        if (tsel_two_q[2]) begin
          cc_sel = 2'h3;
          pwm_sel = 2'h1;
        end
      end
      10: begin
        if (tsel_two_q[4]) begin
          cc_sel = 2'h3;
        end
      end
      default: begin
        cc_sel = 2'h0;
        pwm_sel = 2'h0;
      end
    endcase
  end

  logic [15:0] cc_cnt;
  logic [9:0] pwm_cnt;
  logic pwm_wrap;

  assign cc_cnt = i_timers.cc_cnt[cc_sel];
  assign pwm_cnt = i_timers.pwm_cnt[pwm_sel];
  assign pwm_wrap = i_timers.pwm_wrap[pwm_sel];

  // ---------------------------------------------------------------
  // capture and compare
  // ---------------------------------------------------------------
  logic cap_event;
  logic cap_hit;
  logic eq_q;
  logic eq_now;
  logic cmp_hit;
  logic cmp_pin_q;

  ccpu_cap_edge u_cap_edge (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_clear(op != OP_CAPTURE),
    .i_sel(mode[1:0]),
    .i_pin(i_cap_pin),
    .o_event(cap_event)
  );

  assign cap_hit = (op == OP_CAPTURE) && cap_event;
  assign eq_now = (cc_cnt == {data_high_q, data_low_q});
  // one hit per arrival at the value; reserved codes 0001/0011 stay quiet
  assign cmp_hit = (op == OP_COMPARE) && (mode[3] || mode == `CCPU_MODE_TOGGLE) && eq_now && !eq_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      eq_q <= 1'b0;
    end else if (i_ce) begin
      eq_q <= eq_now && (op == OP_COMPARE);
    end
  end

  // data bytes keep no reset value; a capture outranks a software write
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      if (cap_hit) begin
        data_low_q <= cc_cnt[7:0];
        data_high_q <= cc_cnt[15:8];
      end else if (i_wr) begin
        if (i_addr == `CCPU_OFS_DATA_LOW) begin
          data_low_q <= i_wdata;
        end
        if (i_addr == `CCPU_OFS_DATA_HIGH && op != OP_PWM) begin
          data_high_q <= i_wdata;
        end
      end
      if (op == OP_PWM && pwm_wrap) begin
        data_high_q <= data_low_q;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cmp_pin_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_ctrl && new_mode != mode) begin
        if (new_mode == `CCPU_MODE_SET_HIGH) begin
          cmp_pin_q <= 1'b0;
        end else if (new_mode == `CCPU_MODE_SET_LOW) begin
          cmp_pin_q <= 1'b1;
        end else if (new_mode == `CCPU_MODE_OFF) begin
          cmp_pin_q <= 1'b0;
        end
      end else if (cmp_hit) begin
        case (mode)
          `CCPU_MODE_TOGGLE: cmp_pin_q <= ~cmp_pin_q;
          `CCPU_MODE_SET_HIGH: cmp_pin_q <= 1'b1;
          `CCPU_MODE_SET_LOW: cmp_pin_q <= 1'b0;
          default: cmp_pin_q <= cmp_pin_q;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_flag_set <= 1'b0;
      o_tmr_reset <= 1'b0;
    end else if (i_ce) begin
      o_flag_set <= cap_hit || cmp_hit;
      o_tmr_reset <= cmp_hit && (mode == `CCPU_MODE_TMR_RESET);
    end
  end

  // ---------------------------------------------------------------
  // pwm duty and dead band
  // ---------------------------------------------------------------
  logic [1:0] duty_buf_lsb_q;
  logic [9:0] duty_buf;
  logic pwm_q;
  logic pwm_now;
  logic [3:0] dead_q;
  logic dead_a;
  logic dead_b;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      duty_lsb_q <= 2'h0;
    end else if (i_ce) begin
      duty_lsb_q <= control_q[`CCPU_DUTY_LSB +: 2];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || (i_ce && op != OP_PWM)) begin
      duty_buf_lsb_q <= 2'h0;
    end else if (i_ce && pwm_wrap) begin
      duty_buf_lsb_q <= duty_lsb_q;
    end
  end

  assign duty_buf = {data_high_q, duty_buf_lsb_q};
  assign pwm_now = (op == OP_PWM) && (pwm_cnt < duty_buf);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pwm_q <= 1'b0;
      dead_q <= 4'h0;
    end else if (i_ce) begin
      pwm_q <= pwm_now;
      if (op != OP_PWM) begin
        dead_q <= 4'h0;
      end else if (pwm_now != pwm_q) begin
        dead_q <= 4'(`CCPU_DEAD_CYC);
      end else if (dead_q != 4'h0) begin
        dead_q <= dead_q - 4'h1;
      end
    end
  end

  // both legs stay off until the dead time has run out
  assign dead_a = pwm_q && (dead_q == 4'h0) && (pwm_now == pwm_q);
  assign dead_b = !pwm_q && (dead_q == 4'h0) && (pwm_now == pwm_q);

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic [3:0] pin_out_d;
  logic [3:0] pin_oe_d;

  always_comb begin
    pin_out_d = 4'h0;
    pin_oe_d = 4'h0;
    case (op)
      OP_COMPARE: begin
        if (mode == `CCPU_MODE_TOGGLE || mode == `CCPU_MODE_SET_HIGH || mode == `CCPU_MODE_SET_LOW) begin
          pin_out_d[0] = cmp_pin_q;
          pin_oe_d[0] = 1'b1;
        end
      end
      OP_PWM: begin
        case (ocfg)
          `CCPU_OCFG_SINGLE: begin
            pin_out_d = {4{pwm_q}} & i_steer;
            pin_oe_d = i_steer;
          end
          `CCPU_OCFG_FWD: begin
            pin_out_d = {pwm_q, 2'b00, 1'b1};
            pin_oe_d = 4'hF;
          end
          `CCPU_OCFG_HALF: begin
            pin_out_d = {2'b00, dead_b, dead_a};
            pin_oe_d = 4'h3;
          end
          `CCPU_OCFG_REV: begin
            pin_out_d = {1'b0, 1'b1, pwm_q, 1'b0};
            pin_oe_d = 4'hF;
          end
          default: begin
            pin_out_d = 4'h0;
            pin_oe_d = 4'h0;
          end
        endcase
      end
      default: begin
        pin_out_d = 4'h0;
        pin_oe_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pin_out <= 4'h0;
      o_pin_oe <= 4'h0;
      o_cc_sel <= 2'h0;
      o_pwm_sel <= 2'h0;
    end else if (i_ce) begin
      o_pin_out <= pin_out_d;
      o_pin_oe <= pin_oe_d;
      o_cc_sel <= cc_sel;
      o_pwm_sel <= pwm_sel;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_rd) begin
        case (i_addr)
          `CCPU_OFS_CONTROL: o_rdata <= control_q;
          `CCPU_OFS_DATA_LOW: o_rdata <= data_low_q;
          `CCPU_OFS_DATA_HIGH: o_rdata <= data_high_q;
          `CCPU_OFS_TSEL_ONE: o_rdata <= tsel_one_q;
          `CCPU_OFS_TSEL_TWO: o_rdata <= tsel_two_q;
          default: o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule

// >>> bench/ccpu_unit_chk.sv
/* Port checker for one capture/compare/PWM unit.
   Bound to ccpu_unit; mode and output config are tracked from bus writes. */
`timescale 1ns/10ps
`include "ccpu_consts.svh"
module ccpu_unit_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [`CCPU_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_cap_pin,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe,
  input wire logic o_flag_set,
  input wire logic o_tmr_reset
);
  logic [3:0] mode_q;
  logic [1:0] ocfg_q;
  logic wr_ctl;
  logic pwm;
  assign wr_ctl = i_ce && i_wr && i_addr == `CCPU_OFS_CONTROL;
  assign pwm = mode_q[3:2] == 2'h3;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mode_q <= 4'h0;
      ocfg_q <= 2'h0;
    end else if (wr_ctl) begin
      mode_q <= i_wdata[3:0];
      ocfg_q <= i_wdata[7:6];
    end
  end
  // ----------------------------------------
  // checks: four quiet cycles let registered pins follow a mode write
  // ----------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  AST_RST_CLR: assert property ($fell(i_sys_rst) |-> o_pin_oe == 4'h0 && !o_flag_set && !o_tmr_reset)
    else $error("outputs not clear after reset");
  AST_TMR_RST: assert property (o_tmr_reset |-> o_flag_set && mode_q == `CCPU_MODE_TMR_RESET)
    else $error("timer reset pulse out of place");
  AST_PORT_PINS: assert property ((!pwm)[*4] |-> o_pin_oe[3:1] == 3'h0)
    else $error("pins b to d driven outside pwm");
  AST_ENTER_LOW: assert property (wr_ctl && i_wdata[3:0] == `CCPU_MODE_SET_HIGH &&
    mode_q != `CCPU_MODE_SET_HIGH |-> ##2 o_pin_oe[0] && !o_pin_out[0]) else $error("pin not low on entry");
  AST_FWD: assert property ((pwm && ocfg_q == `CCPU_OCFG_FWD)[*4] |->
    o_pin_oe == 4'hF && o_pin_out[2:0] == 3'h1) else $error("forward bridge levels wrong");
  AST_REV: assert property ((pwm && ocfg_q == `CCPU_OCFG_REV)[*4] |->
    o_pin_oe == 4'hF && !o_pin_out[3] && o_pin_out[2] && !o_pin_out[0]) else $error("reverse bridge levels wrong");
  AST_HALF: assert property ((pwm && ocfg_q == `CCPU_OCFG_HALF)[*4] |->
    o_pin_oe[3:2] == 2'h0 && o_pin_out[1:0] != 2'h3) else $error("half bridge overlap or c/d driven");
  AST_CAP_RISE: assert property ((mode_q == `CCPU_MODE_CAP_RISE)[*4] ##0 $rose(i_cap_pin) |->
    ##[1:2] o_flag_set) else $error("rising edge not captured");
  cover property (o_tmr_reset);
  cover property (mode_q == `CCPU_MODE_CAP_16TH && o_flag_set);
  cover property (ocfg_q == `CCPU_OCFG_HALF && o_pin_out[1]);
endmodule
bind ccpu_unit ccpu_unit_chk u_ccpu_unit_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_cap_pin(i_cap_pin), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_flag_set(o_flag_set), .o_tmr_reset(o_tmr_reset));

// >>> bench/ccpu_far.sv
/* Timer model for the unit's far side.
   Assumes the unit's clock; one count is shown as four offset timers. */
`timescale 1ns/10ps
module ccpu_far #(
  parameter int PWM_PER = 64
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_tmr_reset,
  output ccpu_pkg::ccpu_timers_t o_timers
);
  import ccpu_pkg::*;
  logic [15:0] cnt_q;
  logic [9:0] per_q;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_tmr_reset) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || per_q == 10'(PWM_PER - 1)) begin
      per_q <= 10'h000;
    end else begin
      per_q <= per_q + 10'h001;
    end
  end
  // offsets make a wrong timer pick show up in captured values
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_timers.cc_cnt[k] = cnt_q + {k[3:0], 12'h000};
      o_timers.pwm_cnt[k] = per_q;
      o_timers.pwm_wrap[k] = per_q == 10'h000;
    end
  end
endmodule

// >>> bench/ccpu_unit_tb.sv
/* Self-checking bench for ccpu_unit.
   Assumes unit 4 full-size and unit 8 small-memory side by side, timer model with a 64-count period. */
`timescale 1ns/10ps
`include "ccpu_consts.svh"
module ccpu_unit_tb;
  import ccpu_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cap = 1'b0;
  logic [3:0] steer = 4'h0;
  logic ce = 1'b1;
  logic [7:0] rdata_s;
  logic [3:0] pin_out_s;
  logic [3:0] pin_oe_s;
  logic flag_s;
  logic tmr_rst_s;
  logic [1:0] cc_sel_s;
  logic [1:0] pwm_sel_s;
  logic [7:0] rdata;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic flag;
  logic tmr_rst;
  logic [1:0] cc_sel;
  logic [1:0] pwm_sel;
  ccpu_timers_t timers;
  int num_errors = 0;
  int n_tests = 0;
  always #10 mclk = ~mclk;
  ccpu_unit #(.UNIT_NUM(8), .SMALL_MEM(1'b1)) u_ccpu_unit_small (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_s), .i_timers(timers), .i_cap_pin(cap),
    .i_steer(steer), .o_pin_out(pin_out_s), .o_pin_oe(pin_oe_s), .o_flag_set(flag_s), .o_tmr_reset(tmr_rst_s),
    .o_cc_sel(cc_sel_s), .o_pwm_sel(pwm_sel_s));
  ccpu_unit #(.UNIT_NUM(4), .SMALL_MEM(1'b0)) u_ccpu_unit (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timers(timers), .i_cap_pin(cap),
    .i_steer(steer), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_flag_set(flag), .o_tmr_reset(tmr_rst),
    .o_cc_sel(cc_sel), .o_pwm_sel(pwm_sel));
  ccpu_far #(.PWM_PER(64)) u_ccpu_far (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_tmr_reset(tmr_rst),
    .o_timers(timers));
  // ----------------------------------------
  // helpers: bus tasks start on an edge, checks sample 1 ns after one
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask
  task automatic hi_cnt(input logic [3:0] m, output int h);
    h = 0;
    repeat (64) begin
      tick(1);
      h += int'((pin_out & m) === m);
    end
  endtask
  task automatic t_regs();
    rd_reg(3'h0, 8'h00);
    rd_reg(3'h3, 8'h00);
    rd_reg(3'h4, 8'h00);
    ce <= 1'b0;
    wr_reg(3'h3, 8'h01);
    ce <= 1'b1;
    rd_reg(3'h3, 8'h00);
    wr_reg(3'h3, 8'hFF);
    rd_reg(3'h3, 8'hD7);
    wr_reg(3'h4, 8'hFF);
    rd_reg(3'h4, 8'h17);
    chk(16'(rdata_s), 16'h0003);
    wr_reg(3'h0, 8'hB0);
    rd_reg(3'h0, 8'hB0);
    wr_reg(3'h2, 8'hA5);
    rd_reg(3'h2, 8'hA5);
    wr_reg(3'h5, 8'hFF);
    rd_reg(3'h5, 8'h00);
  endtask
  task automatic t_pick();
    logic [3:0] exp [3] = '{4'h0, 4'h5, 4'h6};
    for (int c = 0; c < 3; c++) begin
      wr_reg(3'h3, 8'(c));
      tick(3);
      chk(16'({cc_sel, pwm_sel}), 16'(exp[c]));
    end
    wr_reg(3'h4, 8'h01);
    tick(3);
    chk(16'({cc_sel_s, pwm_sel_s}), 16'h0001);
    wr_reg(3'h4, 8'h02);
    tick(3);
    chk(16'({cc_sel_s, pwm_sel_s}), 16'h0002);
    wr_reg(3'h4, 8'h00);
    wr_reg(3'h3, 8'h00);
  endtask
  task automatic t_cmp(input logic [3:0] m, input logic oe, input logic pre, input logic tr);
    logic [15:0] v;
    int n;
    wr_reg(3'h0, 8'h00);
    v = timers.cc_cnt[0] + 16'h0040;
    wr_reg(3'h1, v[7:0]);
    wr_reg(3'h2, v[15:8]);
    wr_reg(3'h0, {4'h0, m});
    tick(3);
    chk(16'({pin_oe[0], pin_oe_s[0]}), 16'({oe, oe}));
    if (oe) chk(16'(pin_out[0]), 16'(pre));
    n = 0;
    while (flag !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(timers.cc_cnt[0], v + 16'h0001);
    chk(16'(tmr_rst), 16'(tr));
    chk(16'({flag_s, tmr_rst_s}), 16'({1'b1, tr}));
    tick(1);
    if (oe) chk(16'({pin_out[0], pin_out_s[0]}), 16'({~pre, ~pre}));
    if (tr) chk(timers.cc_cnt[0], 16'h0000);
  endtask
  task automatic t_cap(input logic [3:0] m, input int n);
    logic [15:0] v;
    int f;
    f = 0;
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h0, {4'h0, m});
    tick(4);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk);
      cap <= ~cap;
      #1;
      if (cap == (m != 4'h4)) v = timers.cc_cnt[0];
      repeat (3) begin
        tick(1);
        f += int'(flag === 1'b1);
      end
    end
    chk(16'(f), 16'h0001);
    rd_reg(3'h1, v[7:0]);
    rd_reg(3'h2, v[15:8]);
  endtask
  task automatic t_pwm();
    int h;
    wr_reg(3'h0, 8'h00);
    steer <= 4'h5;
    wr_reg(3'h1, 8'h08);
    wr_reg(3'h0, 8'h3C);
    tick(140);
    hi_cnt(4'h1, h);
    chk(16'(h), 16'h0023);
    chk(16'({pin_oe, pin_out[1]}), 16'h000A);
    wr_reg(3'h2, 8'hEE);
    rd_reg(3'h2, 8'h08);
    wr_reg(3'h0, 8'h7C);
    tick(4);
    chk(16'(pin_out[2:0]), 16'h0001);
    wr_reg(3'h0, 8'hFC);
    tick(4);
    chk(16'({pin_out[3:2], pin_out[0]}), 16'h0002);
    wr_reg(3'h0, 8'hBC);
    tick(4);
    hi_cnt(4'h3, h);
    chk(16'({h[13:0], pin_oe[3:2]}), 16'h0000);
    hi_cnt(4'h1, h);
    chk(16'(h), 16'(8'h23 - `CCPU_DEAD_CYC - 1));
    hi_cnt(4'h2, h);
    chk(16'(h), 16'(8'h40 - 8'h23 - `CCPU_DEAD_CYC - 1));
    wr_reg(3'h0, 8'h00);
    tick(4);
    chk(16'({pin_oe, pin_oe_s}), 16'h0000);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_pick();
    t_cmp(4'h2, 1'b1, 1'b0, 1'b0);
    t_cmp(4'h8, 1'b1, 1'b0, 1'b0);
    t_cmp(4'h9, 1'b1, 1'b1, 1'b0);
    t_cmp(4'hA, 1'b0, 1'b0, 1'b0);
    t_cmp(4'hB, 1'b0, 1'b0, 1'b1);
    t_cap(4'h4, 1);
    t_cap(4'h5, 1);
    t_cap(4'h6, 4);
    t_cap(4'h7, 16);
    t_pwm();
    results();
  end
endmodule
